// ---- verilog/ure_pkg.sv ----
// Purpose: Shared constants and types of the serial transceiver
// Assumes: 32-bit AHB-Lite register access, one core clock
// Notes: Offsets are byte addresses

package ure_pkg;

    // Register byte offsets
    localparam logic [7:0] URE_CTRL_OFS = 8'h00;
    localparam logic [7:0] URE_BAUD_OFS = 8'h04;
    localparam logic [7:0] URE_TXDATA_OFS = 8'h08;
    localparam logic [7:0] URE_RXDATA_OFS = 8'h0C;
    localparam logic [7:0] URE_STATUS_OFS = 8'h10;

    // Control fields
    localparam int URE_CTRL_TXEN = 0;
    localparam int URE_CTRL_RXEN = 1;
    localparam int URE_CTRL_PAREN = 2;
    localparam int URE_CTRL_PARODD = 3;
    localparam int URE_CTRL_STOP2 = 4;
    localparam int URE_CTRL_W = 5;

    // Status fields
    localparam int URE_STAT_TXRDY = 0;
    localparam int URE_STAT_RXVLD = 1;
    localparam int URE_STAT_PERR = 2;
    localparam int URE_STAT_FERR = 3;
    localparam int URE_STAT_TXBUSY = 4;

    // Reset values and divisor minimum
    localparam logic [4:0] URE_CTRL_RST = 5'h00;
    localparam logic [15:0] URE_BAUD_RST = 16'h0001;
    localparam logic [15:0] URE_BAUD_MIN = 16'h0001;

    // Oversampling counts
    localparam logic [2:0] URE_TICK_LAST = 3'h7;
    localparam logic [2:0] URE_HALF_LAST = 3'h3;
    localparam logic [2:0] URE_BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        URE_TX_IDLE,
        URE_TX_START,
        URE_TX_DATA,
        URE_TX_PAR,
        URE_TX_STOP
    } ure_tx_state_t;

    typedef enum logic [1:0] {
        URE_RX_IDLE,
        URE_RX_DATA,
        URE_RX_PAR,
        URE_RX_STOP
    } ure_rx_state_t;

endpackage

// ---- verilog/ure_baud.sv ----
// Purpose: Oversampling tick generator
// Assumes: Divisor of at least one
// Notes: One tick every divisor plus one clocks

`timescale 1ns/1ps

module ure_baud
    import ure_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Configuration
    input wire logic [15:0] divisor,
    // Tick out
    output logic tick
);

    logic [15:0] cnt;

    // Eight ticks make one bit period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt >= divisor) begin
            cnt <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end

endmodule

// ---- verilog/ure_tx.sv ----
// Purpose: Serial transmitter with valid-ready byte input
// Assumes: Tick at eight times the bit rate
// Notes: Holds one byte only, while it shifts out

`timescale 1ns/1ps

module ure_tx
    import ure_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Configuration
    input wire logic en,
    input wire logic par_en,
    input wire logic par_odd,
    input wire logic stop2,
    input wire logic tick,
    // Byte input
    input wire logic data_valid,
    input wire logic [7:0] data,
    output logic ready,
    // Serial line
    output logic serial_out
);

    ure_tx_state_t state;
    logic [2:0] cnt;
    logic [2:0] idx;
    logic [7:0] shreg;
    logic par;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= URE_TX_IDLE;
            ready <= 1'b0;
            serial_out <= 1'b1;
            cnt <= 3'h0;
            idx <= 3'h0;
            shreg <= 8'h00;
            par <= 1'b0;
        end else if (!en) begin
            state <= URE_TX_IDLE;
            ready <= 1'b0;
            serial_out <= 1'b1;
            cnt <= 3'h0;
            idx <= 3'h0;
            shreg <= 8'h00;
        end else if (state == URE_TX_IDLE) begin
            serial_out <= 1'b1;
            ready <= 1'b1;
            if (ready && data_valid && tick) begin
                ready <= 1'b0;
                shreg <= data;
                par <= (^data) ^ par_odd;
                state <= URE_TX_START;
                serial_out <= 1'b0;
                cnt <= 3'h0;
            end
        end else if (tick) begin
            cnt <= cnt + 3'h1;
            if (cnt == URE_TICK_LAST) begin
                case (state)
                    URE_TX_START: begin
                        state <= URE_TX_DATA;
                        serial_out <= shreg[0];
                        idx <= 3'h0;
                    end
                    URE_TX_DATA: begin
                        if (idx == URE_BIT_LAST) begin
                            idx <= 3'h0;
                            state <= par_en ? URE_TX_PAR : URE_TX_STOP;
                            serial_out <= par_en ? par : 1'b1;
                        end else begin
                            idx <= idx + 3'h1;
                            shreg <= {1'b0, shreg[7:1]};
                            serial_out <= shreg[1];
                        end
                    end
                    URE_TX_PAR: begin
                        state <= URE_TX_STOP;
                        serial_out <= 1'b1;
                    end
                    URE_TX_STOP: begin
                        if (stop2 && idx == 3'h0) begin
                            idx <= 3'h1;
                        end else begin
                            state <= URE_TX_IDLE;
                            ready <= 1'b1;
                        end
                    end
                    default: begin
                        state <= URE_TX_IDLE;
                        serial_out <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// ---- verilog/ure_top.sv ----
// Purpose: Serial transceiver with AHB-Lite registers and receiver
// Assumes: One 10 MHz clock, serial input synchronous to it
// Notes: No queueing; one byte held per direction
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.

`timescale 1ns/1ps

module ure_top
    import ure_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Serial line
    input wire logic serial_rx,
    output logic serial_tx
);

    logic [URE_CTRL_W-1:0] ctrl;
    logic [15:0] divisor;
    logic tick;
    logic tx_en;
    logic rx_en;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_ready;
    logic addr_ok;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rx_take;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic par_err;
    logic frame_err;
    logic rx_done;
    ure_rx_state_t rx_state;
    logic [2:0] rx_cnt;
    logic [2:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_par;
    logic stop_bad;
    logic [31:0] next_rdata;

    assign tx_en = ctrl[URE_CTRL_TXEN];
    assign rx_en = ctrl[URE_CTRL_RXEN];
    assign addr_ok = hsel && htrans[1] && hready;
    assign rx_take = addr_ok && !hwrite && haddr[7:0] == URE_RXDATA_OFS && rx_valid;

    // Bus handshake, always zero wait and OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write address capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Read data mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr[7:0])
            URE_CTRL_OFS: begin
                next_rdata[URE_CTRL_W-1:0] = ctrl;
            end
            URE_BAUD_OFS: begin
                next_rdata[15:0] = divisor;
            end
            URE_TXDATA_OFS: begin
                next_rdata[7:0] = tx_byte;
            end
            URE_RXDATA_OFS: begin
                next_rdata[7:0] = (rx_valid && rx_en) ? rx_byte : 8'h00;
            end
            URE_STATUS_OFS: begin
                next_rdata[URE_STAT_TXRDY] = tx_ready && !tx_valid;
                next_rdata[URE_STAT_RXVLD] = rx_valid && rx_en;
                next_rdata[URE_STAT_PERR] = par_err && rx_en;
                next_rdata[URE_STAT_FERR] = frame_err && rx_en;
                next_rdata[URE_STAT_TXBUSY] = tx_en && !tx_ready;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // Control and divisor registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= URE_CTRL_RST;
            divisor <= URE_BAUD_RST;
        end else if (wr_pend) begin
            if (wr_addr == URE_CTRL_OFS) begin
                ctrl <= hwdata[URE_CTRL_W-1:0];
            end
            if (wr_addr == URE_BAUD_OFS) begin
                divisor <= (hwdata[15:0] < URE_BAUD_MIN) ? URE_BAUD_MIN : hwdata[15:0];
            end
        end
    end

    // Transmit holding byte, released on ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else if (!tx_en) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
            if (wr_pend && wr_addr == URE_TXDATA_OFS) begin
                tx_valid <= 1'b1;
                tx_byte <= hwdata[7:0];
            end
        end else if (wr_pend && wr_addr == URE_TXDATA_OFS) begin
            tx_valid <= 1'b1;
            tx_byte <= hwdata[7:0];
        end else if (tx_valid && tx_ready && tick) begin
            tx_valid <= 1'b0;
        end
    end

    // Tick generator shared by both directions
    ure_baud u_baud (
        .hclk(hclk),
        .hresetn(hresetn),
        .divisor(divisor),
        .tick(tick)
    );

    ure_tx u_tx (
        .hclk(hclk),
        .hresetn(hresetn),
        .en(tx_en),
        .par_en(ctrl[URE_CTRL_PAREN]),
        .par_odd(ctrl[URE_CTRL_PARODD]),
        .stop2(ctrl[URE_CTRL_STOP2]),
        .tick(tick),
        .data_valid(tx_valid),
        .data(tx_byte),
        .ready(tx_ready),
        .serial_out(serial_tx)
    );

    // Receive framing, start bit seen low on four ticks, then one sample per bit at its middle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state <= URE_RX_IDLE;
            rx_cnt <= 3'h0;
            rx_idx <= 3'h0;
            rx_sh <= 8'h00;
            rx_par <= 1'b0;
            stop_bad <= 1'b0;
            rx_done <= 1'b0;
        end else if (!rx_en) begin
            rx_state <= URE_RX_IDLE;
            rx_cnt <= 3'h0;
            rx_idx <= 3'h0;
            rx_sh <= 8'h00;
            rx_par <= 1'b0;
            stop_bad <= 1'b0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                case (rx_state)
                    URE_RX_IDLE: begin
                        if (serial_rx) begin
                            rx_cnt <= 3'h0;
                        end else if (rx_cnt == URE_HALF_LAST) begin
                            rx_state <= URE_RX_DATA;
                            rx_cnt <= 3'h0;
                            rx_idx <= 3'h0;
                            stop_bad <= 1'b0;
                        end else begin
                            rx_cnt <= rx_cnt + 3'h1;
                        end
                    end
                    URE_RX_DATA: begin
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == URE_TICK_LAST) begin
                            rx_sh <= {serial_rx, rx_sh[7:1]};
                            rx_idx <= rx_idx + 3'h1;
                            if (rx_idx == URE_BIT_LAST) begin
                                rx_idx <= 3'h0;
                                rx_state <= ctrl[URE_CTRL_PAREN] ? URE_RX_PAR : URE_RX_STOP;
                            end
                        end
                    end
                    URE_RX_PAR: begin
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == URE_TICK_LAST) begin
                            rx_par <= serial_rx;
                            rx_state <= URE_RX_STOP;
                        end
                    end
                    URE_RX_STOP: begin
                        rx_cnt <= rx_cnt + 3'h1;
                        if (rx_cnt == URE_TICK_LAST) begin
                            if (!serial_rx) begin
                                stop_bad <= 1'b1;
                            end
                            if (ctrl[URE_CTRL_STOP2] && rx_idx == 3'h0) begin
                                rx_idx <= 3'h1;
                            end else begin
                                rx_state <= URE_RX_IDLE;
                                rx_cnt <= 3'h0;
                                rx_done <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        rx_state <= URE_RX_IDLE;
                        rx_cnt <= 3'h0;
                    end
                endcase
            end
        end
    end

    // Error flags, held from one frame end to the next
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            par_err <= 1'b0;
            frame_err <= 1'b0;
        end else if (!rx_en) begin
            par_err <= 1'b0;
            frame_err <= 1'b0;
        end else if (rx_done) begin
            frame_err <= stop_bad;
            par_err <= ctrl[URE_CTRL_PAREN] && (rx_par != ((^rx_sh) ^ ctrl[URE_CTRL_PARODD]));
        end
    end

    // Received byte offer; a new byte wins over a take
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else if (!rx_en) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else if (rx_done && !stop_bad) begin
            rx_valid <= 1'b1;
            rx_byte <= rx_sh;
        end else if (rx_take) begin
            rx_valid <= 1'b0;
        end
    end

endmodule

// ---- tb/ure_chk.sv ----
// Purpose: Port assertions for the serial transceiver
// Assumes: Zero wait state bus, one clock
// Notes: Tracks bus phases and receive and transmit enable
`timescale 1ns/1ps
module ure_chk
    import ure_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Serial
    input wire logic serial_tx
);
    logic ph_v;
    logic ph_w;
    logic rx_en;
    logic tx_on;
    logic [7:0] ph_a;
    wire rd_st = ph_v && !ph_w && ph_a == URE_STATUS_OFS;
    wire rd_rx = ph_v && !ph_w && ph_a == URE_RXDATA_OFS;
    wire rd_un = ph_v && !ph_w && ph_a > URE_STATUS_OFS;
    wire wr_ct = ph_v && ph_w && ph_a == URE_CTRL_OFS;
    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v <= 1'b0;
            ph_w <= 1'b0;
            ph_a <= 8'h00;
        end else begin
            ph_v <= hsel && htrans[1] && hready;
            ph_w <= hwrite;
            ph_a <= haddr[7:0];
        end
    end
    // Receive and transmit enable shadows
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_en <= 1'b0;
            tx_on <= 1'b0;
        end else if (wr_ct) begin
            rx_en <= hwdata[URE_CTRL_RXEN];
            tx_on <= hwdata[URE_CTRL_TXEN];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_low8;
        !serial_tx [*8];
    endsequence
    sequence s_high4;
        serial_tx [*4];
    endsequence
    AST_READY: assert property (hreadyout)
        else $error("bus wait state seen");
    AST_OKAY: assert property (!hresp)
        else $error("bus error response seen");
    AST_TX_RST: assert property ($rose(hresetn) |-> serial_tx)
        else $error("serial line low after reset");
    AST_START_LEN: assert property ($fell(serial_tx) |-> s_low8 ##1 s_low8)
        else $error("low bit shorter than sixteen clocks");
    AST_TX_ABORT: assert property (wr_ct && !hwdata[URE_CTRL_TXEN] |-> ##[1:2] s_high4)
        else $error("serial line not released on disable");
    AST_RDY_IDLE: assert property (rd_st && hrdata[URE_STAT_TXRDY] |-> $past(serial_tx))
        else $error("ready while line low");
    AST_RDY_BUSY: assert property (rd_st && tx_on && $past(tx_on) && !$past(serial_tx) |-> hrdata[URE_STAT_TXBUSY])
        else $error("not busy while line low");
    AST_RX_OFF: assert property (rd_st && !rx_en && !$past(rx_en) |-> hrdata[3:1] == 3'h0)
        else $error("receive flags set while disabled");
    AST_RXD_OFF: assert property (rd_rx && !rx_en && !$past(rx_en) |-> hrdata == 32'h0)
        else $error("receive data shown while disabled");
    AST_UNMAPPED: assert property (rd_un |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind ure_top ure_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .serial_tx);

// ---- tb/ure_remote.sv ----
// Purpose: Remote serial device on the far side
// Assumes: Divisor one, sixteen clocks a bit
// Notes: Sends frames on command, captures nine bits of each frame
`timescale 1ns/1ps
module ure_remote
(
    // Clock
    input wire logic hclk,
    // Serial line
    input wire logic serial_tx,
    output logic serial_rx
);
    localparam int BIT = 16;
    logic [8:0] got;
    initial serial_rx = 1'b1;
    task automatic line(input logic v, input int len);
        serial_rx <= v;
        repeat (len) @(posedge hclk);
    endtask
    // Bad: 0 good stop, 1 short low stop, 2 full low stop
    task automatic send(input logic [7:0] b, input logic pen, input logic pbit, input logic two,
        input logic [1:0] bad, input logic nostart);
        if (!nostart) line(1'b0, BIT);
        for (int i = 0; i < 8; i++) line(b[i], BIT);
        if (pen) line(pbit, BIT);
        if (two) line(1'b1, BIT);
        if (bad == 2'h0) begin
            line(1'b1, BIT);
        end else if (bad == 2'h1) begin
            line(1'b0, BIT / 2 + 2);
            line(1'b1, BIT);
        end else begin
            line(1'b0, BIT);
        end
    endtask
    // Capture of the transmitted line
    always begin
        @(negedge serial_tx);
        repeat (BIT / 2) @(negedge hclk);
        if (serial_tx === 1'b0) begin
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(negedge hclk);
                got[i] = serial_tx;
            end
        end
    end
endmodule

// ---- tb/test_ure_top.sv ----
// Purpose: Register level test of the serial transceiver
// Assumes: Divisor one, zero wait state bus
// Notes: Remote model drives and watches the line
`timescale 1ns/1ps
module test_ure_top
    import ure_pkg::*;
;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    localparam logic [31:0] FLG = 32'h0000000E;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, serial_rx, serial_tx;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    int n_fail, samples_checked, cyc, t0;
    ure_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .serial_rx, .serial_tx);
    ure_remote rem (.hclk, .serial_tx, .serial_rx);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(name, q & m, e);
    endtask
    task automatic wait_st(input int b, input logic v);
        for (int i = 0; i < 300; i++) begin
            bus(1'b0, URE_STATUS_OFS, 32'h0);
            if (q[b] === v) break;
        end
    endtask
    task automatic tx_frame(input logic [4:0] c, input logic [7:0] b, input int n, input logic [8:0] e);
        bus(1'b1, URE_CTRL_OFS, 32'h0);
        bus(1'b1, URE_CTRL_OFS, {27'h0, c});
        bus(1'b1, URE_TXDATA_OFS, {24'h0, b});
        rd_chk("tx_ready", URE_STATUS_OFS, 32'h1, 32'h0);
        t0 = cyc;
        wait_st(URE_STAT_TXRDY, 1'b1);
        chk("tx_time", 32'(cyc - t0 >= n * 16 - 8 && cyc - t0 <= n * 16 + 16), 32'h1);
        chk("tx_line", 32'(rem.got), 32'(e));
    endtask
    task automatic rx_frame(input logic [4:0] c, input logic [7:0] b, input logic p, input logic [1:0] bad,
        input logic [2:0] f, input logic [7:0] d);
        bus(1'b1, URE_CTRL_OFS, 32'h0);
        bus(1'b1, URE_CTRL_OFS, {27'h0, c});
        rd_chk("rx_early", URE_RXDATA_OFS, ALL, 32'h0);
        rem.send(b, c[2], p, c[4], bad, 1'b0);
        repeat (20) @(posedge hclk);
        rd_chk("rx_flags", URE_STATUS_OFS, FLG, {28'h0, f, 1'b0});
        rd_chk("rx_data", URE_RXDATA_OFS, ALL, {24'h0, d});
        rd_chk("rx_taken", URE_STATUS_OFS, FLG, {28'h0, f[2:1], 2'b00});
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("tx_idle", 32'(serial_tx), 32'h1);
        rd_chk("ctrl", URE_CTRL_OFS, ALL, 32'(URE_CTRL_RST));
        rd_chk("baud", URE_BAUD_OFS, ALL, 32'(URE_BAUD_RST));
        bus(1'b1, URE_BAUD_OFS, 32'h0);
        rd_chk("baud_min", URE_BAUD_OFS, ALL, 32'(URE_BAUD_MIN));
        bus(1'b1, 8'h14, 32'h5);
        rd_chk("unmapped", 8'h14, ALL, 32'h0);
        $display("test registers done");
        tx_frame(5'h01, 8'h5A, 10, 9'h15A);
        tx_frame(5'h05, 8'h5B, 11, 9'h15B);
        tx_frame(5'h0D, 8'h5B, 11, 9'h05B);
        tx_frame(5'h11, 8'h5A, 11, 9'h15A);
        $display("test transmit done");
        bus(1'b1, URE_CTRL_OFS, 32'h1);
        bus(1'b1, URE_TXDATA_OFS, 32'h0);
        bus(1'b1, URE_TXDATA_OFS, 32'h0);
        repeat (60) @(posedge hclk);
        bus(1'b1, URE_CTRL_OFS, 32'h0);
        repeat (2) @(posedge hclk);
        chk("tx_abort", 32'(serial_tx), 32'h1);
        bus(1'b1, URE_CTRL_OFS, 32'h1);
        repeat (40) @(posedge hclk);
        chk("tx_cleared", 32'(serial_tx), 32'h1);
        bus(1'b1, URE_CTRL_OFS, 32'h0);
        repeat (200) @(posedge hclk);
        $display("test abort done");
        rx_frame(5'h02, 8'hA5, 1'b0, 2'h0, 3'b001, 8'hA5);
        rx_frame(5'h06, 8'h3C, 1'b0, 2'h0, 3'b001, 8'h3C);
        rx_frame(5'h0E, 8'h3C, 1'b1, 2'h0, 3'b001, 8'h3C);
        rx_frame(5'h06, 8'h3C, 1'b1, 2'h0, 3'b011, 8'h3C);
        rx_frame(5'h12, 8'h81, 1'b0, 2'h1, 3'b100, 8'h00);
        rx_frame(5'h02, 8'h81, 1'b0, 2'h1, 3'b100, 8'h00);
        $display("test receive done");
        bus(1'b1, URE_CTRL_OFS, 32'h0);
        bus(1'b1, URE_CTRL_OFS, 32'h2);
        rem.send(8'h11, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0);
        rem.send(8'h96, 1'b0, 1'b0, 1'b0, 2'h0, 1'b1);
        repeat (20) @(posedge hclk);
        rd_chk("resync_flags", URE_STATUS_OFS, FLG, 32'h2);
        rd_chk("resync_data", URE_RXDATA_OFS, ALL, 32'h96);
        fork
            rem.send(8'h3F, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
            begin
                repeat (80) @(posedge hclk);
                bus(1'b1, URE_CTRL_OFS, 32'h0);
                rd_chk("rx_off", URE_RXDATA_OFS, ALL, 32'h0);
            end
        join
        bus(1'b1, URE_CTRL_OFS, 32'h2);
        repeat (20) @(posedge hclk);
        rd_chk("drop_flags", URE_STATUS_OFS, FLG, 32'h0);
        rd_chk("drop_data", URE_RXDATA_OFS, ALL, 32'h0);
        $display("test resync and disable done");
        print_verdict();
    end
endmodule
